//--- logic/phspc_top.sv
// Processor-hot status register, alert pulse control and protection-mode status
//
// Contract
// - With stretch enabled the alert pin stays low after a trigger until the host writes the clear bit to zero; enable resets to 0.
// - With stretch disabled the alert pulse lasts at least the width picked by the 2-bit field (100us, 1ms, 10ms default, 5ms).
// - With stretch enabled a host write of zero to the clear bit ends the pulse and releases the pin; the bit idles at one.
// - Seven consecutive failed supply loads in protection mode set the protection failure flag.
// - After such a failure the mode is left and stays latched off until the host writes the failure flag to zero.
// - Protection mode is left when the host disables it or when any charger fault occurs.
// - While the protection exit flag is set the alert pin is held low until the host writes that flag to zero; it resets to 0.
// - The low byte holds eight trigger-source flags, each reading 1 when triggered and resetting to 0.
`timescale 1ns/1ps
`default_nettype none
module phspc_top
  import phspc_pkg::*;
#(
  parameter int unsigned CYC_100US = PHSPC_CYC_100US,
  parameter int unsigned CYC_1MS   = PHSPC_CYC_1MS,
  parameter int unsigned CYC_10MS  = PHSPC_CYC_10MS,
  parameter int unsigned CYC_5MS   = PHSPC_CYC_5MS
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  // Trigger sources
  input  wire logic [7:0] trig_event,
  input  wire logic [7:0] trig_enable,
  // Protection mode
  input  wire logic       prot_enable,
  input  wire logic       charger_fault,
  input  wire logic       prot_load_fail,
  input  wire logic       prot_load_ok,
  output logic            prot_active,
  output logic            prot_latched_off,
  // Open-drain alert pin
  input  wire logic       processor_hot_alert_pin_i,
  output logic            processor_hot_alert_pin_o,
  output logic            processor_hot_alert_pin_oe
);

  // ==========================================================
  // Parameter checks
  localparam int unsigned CNT_MAX = (1 << PHSPC_CNT_W) - 1;
  if (CYC_100US == 0 || CYC_1MS == 0 || CYC_10MS == 0 || CYC_5MS == 0 ||
      CYC_100US > CNT_MAX || CYC_1MS > CNT_MAX || CYC_10MS > CNT_MAX || CYC_5MS > CNT_MAX)
  begin : g_bad_cnt
    $error("pulse width counts must lie between 1 and the counter range");
  end

  // ==========================================================
  // Write decode
  wire logic wr_hi = reg_wr && (reg_addr == PHSPC_ADDR_HI);
  wire logic wr_lo = reg_wr && (reg_addr == PHSPC_ADDR_LO);
  wire logic clr_pulse = wr_hi && !reg_wdata[PHSPC_HI_PULSE_CLEAR];
  wire logic clr_fail  = wr_hi && !reg_wdata[PHSPC_HI_FAIL_FLAG];
  wire logic clr_exit  = wr_hi && !reg_wdata[PHSPC_HI_EXIT_FLAG];
  wire logic [7:0] clr_src = wr_lo ? ~reg_wdata : 8'h00;

  // ==========================================================
  // Control fields
  logic       stretch_en_reg;
  logic [1:0] width_reg;
  logic       clear_reg;

  // The clear bit reads back zero for one cycle after a clear, then idles at one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stretch_en_reg <= PHSPC_RST_STRETCH_EN;
      width_reg      <= PHSPC_RST_WIDTH;
      clear_reg      <= PHSPC_RST_CLEAR;
    end
    else if (wr_hi)
    begin
      stretch_en_reg <= reg_wdata[PHSPC_HI_STRETCH_EN];
      width_reg      <= reg_wdata[PHSPC_HI_WIDTH_MSB:PHSPC_HI_WIDTH_LSB];
      clear_reg      <= reg_wdata[PHSPC_HI_PULSE_CLEAR];
    end
    else
      clear_reg <= PHSPC_RST_CLEAR;
  end

  // ==========================================================
  // Trigger-source flags
  logic [7:0] src_flag_reg;
  wire  logic [7:0] trig_hit = trig_event & trig_enable;
  wire  logic       any_trig = |trig_hit;

  // Set wins over a clear written in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      src_flag_reg <= PHSPC_RST_FLAGS;
    else
      src_flag_reg <= (src_flag_reg & ~clr_src) | trig_hit;
  end

  // ==========================================================
  // Protection mode
  phspc_prot_state_t prot_state_reg;
  phspc_prot_state_t prot_state_next;
  logic [2:0]        fail_cnt_reg;
  logic              fail_flag_reg;
  logic              exit_flag_reg;

  wire logic in_prot    = (prot_state_reg == PHSPC_PROT_ACTIVE);
  wire logic prot_leave = in_prot && (!prot_enable || charger_fault);
  wire logic fail_limit = in_prot && prot_load_fail && !prot_leave &&
                          (fail_cnt_reg == PHSPC_FAIL_LIMIT - 3'h1);

  always_comb
  begin
    prot_state_next = prot_state_reg;
    case (prot_state_reg)
      PHSPC_PROT_IDLE:
        if (prot_enable && !charger_fault)
          prot_state_next = PHSPC_PROT_ACTIVE;
      PHSPC_PROT_ACTIVE:
        if (prot_leave)
          prot_state_next = PHSPC_PROT_IDLE;
        else if (fail_limit)
          prot_state_next = PHSPC_PROT_LATCHED;
      PHSPC_PROT_LATCHED:
        if (!fail_flag_reg)
          prot_state_next = PHSPC_PROT_IDLE;
      default:
        prot_state_next = PHSPC_PROT_IDLE;
    endcase
  end

  // A success breaks the run, so only back-to-back failures count
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prot_state_reg <= PHSPC_PROT_IDLE;
      fail_cnt_reg   <= 3'h0;
    end
    else
    begin
      prot_state_reg <= prot_state_next;
      if (!in_prot || prot_load_ok || fail_limit)
        fail_cnt_reg <= 3'h0;
      else if (prot_load_fail)
        fail_cnt_reg <= fail_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fail_flag_reg <= 1'b0;
      exit_flag_reg <= 1'b0;
    end
    else
    begin
      fail_flag_reg <= fail_limit | (fail_flag_reg & ~clr_fail);
      exit_flag_reg <= prot_leave | (exit_flag_reg & ~clr_exit);
    end
  end

  assign prot_active      = in_prot;
  assign prot_latched_off = (prot_state_reg == PHSPC_PROT_LATCHED);

  // ==========================================================
  // Pulse timer
  phspc_pulse_if pif ();

  assign pif.start      = any_trig;
  assign pif.stretch_en = stretch_en_reg;
  assign pif.clear      = clr_pulse;
  assign pif.term_cnt   = (width_reg == PHSPC_WIDTH_100US) ? PHSPC_CNT_W'(CYC_100US) :
                          (width_reg == PHSPC_WIDTH_1MS)   ? PHSPC_CNT_W'(CYC_1MS)   :
                          (width_reg == PHSPC_WIDTH_10MS)  ? PHSPC_CNT_W'(CYC_10MS)  :
                                                             PHSPC_CNT_W'(CYC_5MS);

  phspc_pulse_timer u_timer
  (
    .clk    (clk),
    .arst_n (arst_n),
    .pif    (pif.tmr)
  );

  // Open drain: only ever pulls low
  assign processor_hot_alert_pin_o  = 1'b0;
  assign processor_hot_alert_pin_oe = pif.active | exit_flag_reg;

  // ==========================================================
  // Read path
  wire logic [7:0] hi_byte = {1'b1, stretch_en_reg, width_reg, clear_reg, 1'b0, fail_flag_reg, exit_flag_reg};
  wire logic [7:0] rd_mux  = (reg_addr == PHSPC_ADDR_HI) ? hi_byte :
                             (reg_addr == PHSPC_ADDR_LO) ? src_flag_reg : 8'h00;

  // Pin level is neither sampled nor read back; it only ties off the input port
  wire logic unused_pin = processor_hot_alert_pin_i;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Checks
  chk_trigger_pulls_low: assert property (@(posedge clk) disable iff (!arst_n)
    any_trig |=> processor_hot_alert_pin_oe && ((src_flag_reg & $past(trig_hit)) == $past(trig_hit)))
    else $error("trigger did not pull the alert pin low and set its flag");

  chk_exit_holds_pin: assert property (@(posedge clk) disable iff (!arst_n)
    exit_flag_reg && !clr_exit |=> exit_flag_reg && processor_hot_alert_pin_oe)
    else $error("exit flag or alert pin dropped without a host clear");

  chk_flags_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_lo |=> (src_flag_reg & $past(src_flag_reg)) == $past(src_flag_reg))
    else $error("trigger flag cleared without a host write");

  chk_seventh_fail_latch: assert property (@(posedge clk) disable iff (!arst_n)
    in_prot && prot_enable && !charger_fault && prot_load_fail && fail_cnt_reg == 3'h6
    |=> fail_flag_reg && prot_latched_off)
    else $error("seventh failure did not latch the mode off");

  // The flag clears one edge before the state leaves, so the flag is part of the antecedent
  chk_latch_until_clear: assert property (@(posedge clk) disable iff (!arst_n)
    prot_latched_off && fail_flag_reg && !clr_fail |=> prot_latched_off && fail_flag_reg)
    else $error("latched-off state left without a host clear");

  chk_fault_exits_mode: assert property (@(posedge clk) disable iff (!arst_n)
    in_prot && (charger_fault || !prot_enable) |=> !in_prot && exit_flag_reg)
    else $error("protection mode not left on fault or disable");

  chk_clear_releases_pin: assert property (@(posedge clk) disable iff (!arst_n)
    stretch_en_reg && pif.active && clr_pulse && !any_trig && !exit_flag_reg && !prot_leave
    |=> !processor_hot_alert_pin_oe)
    else $error("host clear did not release the stretched alert");

endmodule
`default_nettype wire

//--- logic/phspc_pkg.sv
// Package: register map, field positions, reset values and pulse timing for the alert block
package phspc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  PHSPC_ADDR_LO      = 8'h22;
  localparam logic [7:0]  PHSPC_ADDR_HI      = 8'h23;
  localparam logic [15:0] PHSPC_RESET_VALUE  = 16'hA800;

  // ==========================================================
  // Field positions inside the high byte
  localparam int PHSPC_HI_RSVD_ONE    = 7;
  localparam int PHSPC_HI_STRETCH_EN  = 6;
  localparam int PHSPC_HI_WIDTH_MSB   = 5;
  localparam int PHSPC_HI_WIDTH_LSB   = 4;
  localparam int PHSPC_HI_PULSE_CLEAR = 3;
  localparam int PHSPC_HI_FAIL_FLAG   = 1;
  localparam int PHSPC_HI_EXIT_FLAG   = 0;

  // ==========================================================
  // Reset values of the fields
  localparam logic       PHSPC_RST_STRETCH_EN = 1'h0;
  localparam logic [1:0] PHSPC_RST_WIDTH      = 2'h2;
  localparam logic       PHSPC_RST_CLEAR      = 1'h1;
  localparam logic [7:0] PHSPC_RST_FLAGS      = 8'h00;

  // ==========================================================
  // Width encodings
  localparam logic [1:0] PHSPC_WIDTH_100US = 2'h0;
  localparam logic [1:0] PHSPC_WIDTH_1MS   = 2'h1;
  localparam logic [1:0] PHSPC_WIDTH_10MS  = 2'h2;
  localparam logic [1:0] PHSPC_WIDTH_5MS   = 2'h3;

  // ==========================================================
  // Timing
  localparam int unsigned PHSPC_CLK_PERIOD_NS = 50;
  localparam int unsigned PHSPC_T100US_NS     = 100000;
  localparam int unsigned PHSPC_T1MS_NS       = 1000000;
  localparam int unsigned PHSPC_T10MS_NS      = 10000000;
  localparam int unsigned PHSPC_T5MS_NS       = 5000000;
  localparam int unsigned PHSPC_CYC_100US =
    (PHSPC_T100US_NS + PHSPC_CLK_PERIOD_NS - 1) / PHSPC_CLK_PERIOD_NS;
  localparam int unsigned PHSPC_CYC_1MS =
    (PHSPC_T1MS_NS + PHSPC_CLK_PERIOD_NS - 1) / PHSPC_CLK_PERIOD_NS;
  localparam int unsigned PHSPC_CYC_10MS =
    (PHSPC_T10MS_NS + PHSPC_CLK_PERIOD_NS - 1) / PHSPC_CLK_PERIOD_NS;
  localparam int unsigned PHSPC_CYC_5MS =
    (PHSPC_T5MS_NS + PHSPC_CLK_PERIOD_NS - 1) / PHSPC_CLK_PERIOD_NS;
  localparam int          PHSPC_CNT_W     = 18;

  // ==========================================================
  // Protection mode
  localparam logic [2:0] PHSPC_FAIL_LIMIT = 3'h7;

  typedef enum logic [1:0]
  {
    PHSPC_PROT_IDLE    = 2'h0,
    PHSPC_PROT_ACTIVE  = 2'h1,
    PHSPC_PROT_LATCHED = 2'h3
  } phspc_prot_state_t;

endpackage

//--- logic/phspc_pulse_if.sv
// Interface: control and status between the register bank and the pulse timer
`timescale 1ns/1ps
`default_nettype none
interface phspc_pulse_if;
  import phspc_pkg::*;
  logic                   start;
  logic                   stretch_en;
  logic                   clear;
  logic [PHSPC_CNT_W-1:0] term_cnt;
  logic                   active;
  modport ctrl (output start, output stretch_en, output clear, output term_cnt, input active);
  modport tmr  (input start, input stretch_en, input clear, input term_cnt, output active);
endinterface
`default_nettype wire

//--- logic/phspc_pulse_timer.sv
// Alert pulse timer: minimum low width or host-cleared stretch
`timescale 1ns/1ps
`default_nettype none
module phspc_pulse_timer
  import phspc_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    arst_n,
  // Control
  phspc_pulse_if.tmr   pif
);

  // ==========================================================
  // Counter
  logic [PHSPC_CNT_W-1:0] cnt_reg;
  logic                   active_reg;
  wire logic              cnt_zero = (cnt_reg == '0);
  wire logic              release_now = pif.stretch_en ? pif.clear : cnt_zero;

  // A new trigger restarts the width, so with stretch disabled the last event always gets full width
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
    end
    else if (pif.start)
    begin
      cnt_reg    <= pif.term_cnt - PHSPC_CNT_W'(1);
      active_reg <= 1'b1;
    end
    else
    begin
      if (!cnt_zero)
        cnt_reg <= cnt_reg - PHSPC_CNT_W'(1);
      if (active_reg && release_now)
        active_reg <= 1'b0;
    end
  end

  assign pif.active = active_reg;

  // ==========================================================
  // Checks
  chk_width_holds_min: assert property (@(posedge clk) disable iff (!arst_n)
    active_reg && !pif.stretch_en && !cnt_zero |=> active_reg)
    else $error("alert pulse ended before its minimum width");

  chk_width_ends_on_time: assert property (@(posedge clk) disable iff (!arst_n)
    active_reg && !pif.stretch_en && cnt_zero && !pif.start |=> !active_reg)
    else $error("alert pulse outlasted its width");

  chk_stretch_holds_low: assert property (@(posedge clk) disable iff (!arst_n)
    active_reg && pif.stretch_en && !pif.clear |=> active_reg)
    else $error("stretched pulse ended without a host clear");

endmodule
`default_nettype wire

//--- tb/phspc_alert_monitor.sv
// Partner model: pulled-up open-drain alert line and low-pulse width meter
`timescale 1ns/1ps
`default_nettype none
module phspc_alert_monitor
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Open-drain drive from the block
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  // Resolved line and last low width in cycles
  output logic            pin_level,
  output logic [7:0]      low_len
);
  logic [7:0] run_reg;

  // ==========================================================
  // Line resolution
  // Pull-up makes the line high whenever the block lets go
  assign pin_level = pin_oe ? pin_o : 1'b1;

  // ==========================================================
  // Width meter
  // Counts low samples; latches the run when the line returns high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_reg <= 8'h00;
      low_len <= 8'h00;
    end
    else if (!pin_level)
    begin
      run_reg <= run_reg + 8'h01;
    end
    else if (run_reg != 8'h00)
    begin
      low_len <= run_reg;
      run_reg <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tb/processor_hot_status_pulse_test.sv
// Testbench: register, alert pulse and protection-mode checks for the alert block
`timescale 1ns/1ps
`default_nettype none
module processor_hot_status_pulse_test;
  import phspc_pkg::*;
  // Shortened counts keep the run brief
  localparam int unsigned P100 = 4;
  localparam int unsigned P1M  = 8;
  localparam int unsigned P10M = 16;
  localparam int unsigned P5M  = 12;

  logic       clk, arst_n, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, trig_event, trig_enable, low_len;
  logic       prot_enable, charger_fault, prot_load_fail, prot_load_ok, prot_active, prot_latched_off;
  logic       pin_level, pin_o, pin_oe;
  logic [31:0] rnd;
  logic [2:0] idx;
  int         num_errors, tests_run, seed, k;

  phspc_top #(.CYC_100US(P100), .CYC_1MS(P1M), .CYC_10MS(P10M), .CYC_5MS(P5M)) dut_u (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .trig_event(trig_event), .trig_enable(trig_enable), .prot_enable(prot_enable),
    .charger_fault(charger_fault), .prot_load_fail(prot_load_fail), .prot_load_ok(prot_load_ok),
    .prot_active(prot_active), .prot_latched_off(prot_latched_off),
    .processor_hot_alert_pin_i(pin_level), .processor_hot_alert_pin_o(pin_o),
    .processor_hot_alert_pin_oe(pin_oe));

  phspc_alert_monitor mon_u (.clk(clk), .arst_n(arst_n), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_level(pin_level), .low_len(low_len));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] exp_width(input logic [1:0] code);
    case (code)
      PHSPC_WIDTH_100US: return 8'(P100);
      PHSPC_WIDTH_1MS:   return 8'(P1M);
      PHSPC_WIDTH_10MS:  return 8'(P10M);
      default:           return 8'(P5M);
    endcase
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    int n;
    reg_rd = 1'b1; reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    check("read valid", {7'h00, reg_rvalid}, 8'h01);
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) step(1);
    d = reg_rdata;
    step(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_read(a, v);
    check("register read", v, exp);
  endtask

  task automatic fire(input logic [2:0] i, input logic [7:0] en);
    trig_enable = en; trig_event = 8'h01 << i;
    step(1);
    trig_event = 8'h00;
  endtask

  task automatic fails(input int n);
    repeat (n)
    begin
      prot_load_fail = 1'b1;
      step(1);
      prot_load_fail = 1'b0;
      step(1);
    end
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    step(20);
    arst_n = 1'b1;
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 26675;
    {reg_wr, reg_rd, reg_addr, reg_wdata, trig_event, trig_enable} = '0;
    {prot_enable, charger_fault, prot_load_fail, prot_load_ok} = '0;
    do_reset();
    rd_chk(PHSPC_ADDR_HI, 8'hA8);
    rd_chk(PHSPC_ADDR_LO, 8'h00);
    rd_chk(8'h21, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      reg_write(PHSPC_ADDR_HI, 8'h08 | (8'(k) << 4));
      rd_chk(PHSPC_ADDR_HI, 8'h88 | (8'(k) << 4));
      rnd = $random(seed);
      idx = rnd[2:0];
      fire(idx, rnd[15:8] | (8'h01 << idx));
      step(24);
      check("pulse width", low_len, exp_width(2'(k)));
      rd_chk(PHSPC_ADDR_LO, 8'h01 << idx);
      reg_write(PHSPC_ADDR_LO, 8'hFF);
      rd_chk(PHSPC_ADDR_LO, 8'h01 << idx);
      reg_write(PHSPC_ADDR_LO, 8'h00);
      rd_chk(PHSPC_ADDR_LO, 8'h00);
    end
    fire(3'h3, 8'hF7);
    step(2);
    check("pin idle", {7'h00, pin_level}, 8'h01);
    rd_chk(PHSPC_ADDR_LO, 8'h00);
    // Stretch: pin must outlast the shortest width until the clear write
    reg_write(PHSPC_ADDR_HI, 8'h48);
    fire(3'h5, 8'h20);
    step(20);
    check("pin stretched", {7'h00, pin_level}, 8'h00);
    reg_write(PHSPC_ADDR_HI, 8'h40);
    check("pin released", {7'h00, pin_level}, 8'h01);
    rd_chk(PHSPC_ADDR_HI, 8'hC8);
    reg_write(PHSPC_ADDR_LO, 8'h00);
    // Protection mode failure count, reset by a good load
    reg_write(PHSPC_ADDR_HI, 8'h08);
    prot_enable = 1'b1;
    step(2);
    check("mode active", {7'h00, prot_active}, 8'h01);
    fails(6);
    prot_load_ok = 1'b1;
    step(1);
    prot_load_ok = 1'b0;
    step(1);
    fails(6);
    check("latched early", {7'h00, prot_latched_off}, 8'h00);
    fails(1);
    check("latched", {7'h00, prot_latched_off}, 8'h01);
    check("mode left", {7'h00, prot_active}, 8'h00);
    rd_chk(PHSPC_ADDR_HI, 8'h8A);
    prot_enable = 1'b0;
    step(3);
    check("latch held", {7'h00, prot_latched_off}, 8'h01);
    reg_write(PHSPC_ADDR_HI, 8'h08);
    step(1);
    check("latch cleared", {7'h00, prot_latched_off}, 8'h00);
    rd_chk(PHSPC_ADDR_HI, 8'h88);
    // Exit by fault, then by host disable
    for (k = 0; k < 2; k++)
    begin
      prot_enable = 1'b1;
      step(2);
      check("mode entered", {7'h00, prot_active}, 8'h01);
      if (k == 0) charger_fault = 1'b1;
      else prot_enable = 1'b0;
      step(2);
      check("mode exit", {7'h00, prot_active}, 8'h00);
      step(30);
      check("pin exit hold", {7'h00, pin_level}, 8'h00);
      rd_chk(PHSPC_ADDR_HI, 8'h89);
      charger_fault = 1'b0;
      prot_enable = 1'b0;
      reg_write(PHSPC_ADDR_HI, 8'h08);
      step(1);
      check("pin exit free", {7'h00, pin_level}, 8'h01);
      rd_chk(PHSPC_ADDR_HI, 8'h88);
    end
    // Reset in mid-run restores the defaults
    reg_write(PHSPC_ADDR_HI, 8'h70);
    fire(3'h2, 8'h04);
    do_reset();
    check("pin after reset", {7'h00, pin_level}, 8'h01);
    rd_chk(PHSPC_ADDR_HI, 8'hA8);
    rd_chk(PHSPC_ADDR_LO, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
